// ===== accs_pkg.sv
// Constants and carrier types for the conversion cycle sequencer
package accs_pkg;

  // Serial word layout
  localparam int          WORD_BITS  = 32;
  localparam int          DATA_BITS  = 24;
  localparam int          IN_BITS    = 8;
  localparam int          ADDR_BITS  = 5;
  localparam int          CTRL_BITS  = 3;
  localparam int          CNT_W      = 6;
  localparam int          HDR_BITS   = 2;

  // Input word control codes
  localparam logic [2:0]  CTRL_LOAD  = 3'h5;
  localparam logic [2:0]  CTRL_KEEP  = 3'h4;
  localparam logic [2:0]  CTRL_ZERO  = 3'h0;
  localparam logic [4:0]  ADDR_RESET = 5'h00;

  // Output word header and range codes
  localparam logic [1:0]  HDR_READY  = 2'h0;
  localparam logic [23:0] OVER_DATA  = 24'h800000;
  localparam logic [23:0] UNDER_DATA = 24'h7FFFFF;

  // Synchronised pin positions
  localparam int          PIN_CS     = 0;
  localparam int          PIN_SCK    = 1;
  localparam int          PIN_SDI    = 2;
  localparam int          PIN_SUP    = 3;
  localparam int          PIN_N      = 4;
  localparam logic [3:0]  PIN_IDLE   = 4'hB;

  // Timing
  localparam int          CLK_MHZ    = 200;
  localparam int          POR_TIME_MS = 1;
  localparam int          POR_CYC    = POR_TIME_MS * CLK_MHZ * 1000;
  localparam int          CONV_CYC   = 2048;
  localparam int          CAL_CYC    = 256;
  localparam int          SCK_HALF   = 16;

  typedef enum logic [1:0] {
    ACCS_POR,
    ACCS_CONV,
    ACCS_SLEEP,
    ACCS_DOUT
  } accs_state_e;

  // Raw result from the modulator and filter
  typedef struct packed {
    logic        over;
    logic        under;
    logic [23:0] data;
  } accs_result_s;

endpackage

// ===== accs_sequencer.sv
// Conversion, sleep and serial data cycle sequencer
module accs_sequencer #(
  parameter int POR_CYCLES  = accs_pkg::POR_CYC,
  parameter int CONV_CYCLES = accs_pkg::CONV_CYC,
  parameter int CAL_CYCLES  = accs_pkg::CAL_CYC,
  parameter int SCK_HALF    = accs_pkg::SCK_HALF
) (
  // Clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  en_i,
  // Supply monitor
  input  wire logic                  supply_ok_i,
  // Serial pins
  input  wire logic                  cs_n_i,
  input  wire logic                  sck_i,
  output logic                       sck_o,
  output logic                       sck_oe_o,
  input  wire logic                  sdi_i,
  output logic                       sdo_o,
  output logic                       sdo_oe_o,
  // Converter datapath
  input  wire accs_pkg::accs_result_s result_i,
  output logic [4:0]                 mux_address_o,
  output logic                       conv_start_o,
  output logic                       cal_offset_o,
  output logic                       cal_fullscale_o,
  output logic                       sleep_o,
  output logic                       ext_sck_mode_o
);

  localparam int POR_W  = $clog2(POR_CYCLES + 1);
  localparam int CONV_W = $clog2(CONV_CYCLES + 1);
  localparam int DIV_W  = $clog2(SCK_HALF + 1);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [accs_pkg::PIN_N-1:0] pins_raw;
  logic [accs_pkg::PIN_N-1:0] s1;
  logic [accs_pkg::PIN_N-1:0] s2;
  logic [accs_pkg::PIN_N-1:0] s3;
  logic [accs_pkg::PIN_N-1:0] filt;
  logic [accs_pkg::PIN_N-1:0] filt_q;
  logic [accs_pkg::PIN_N-1:0] next_filt;

  assign pins_raw = {supply_ok_i, sdi_i, sck_i, cs_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < accs_pkg::PIN_N; gi++) begin : g_sync
      assign next_filt[gi] = (s2[gi] == s3[gi]) ? s2[gi] : filt[gi];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1     <= accs_pkg::PIN_IDLE;
      s2     <= accs_pkg::PIN_IDLE;
      s3     <= accs_pkg::PIN_IDLE;
      filt   <= accs_pkg::PIN_IDLE;
      filt_q <= accs_pkg::PIN_IDLE;
    end else if (en_i) begin
      s1     <= pins_raw;
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_q <= filt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer state
  accs_pkg::accs_state_e state;
  accs_pkg::accs_state_e next_state;
  logic [POR_W-1:0]      por_cnt;
  logic [POR_W-1:0]      next_por_cnt;
  logic [CONV_W-1:0]     conv_cnt;
  logic [CONV_W-1:0]     next_conv_cnt;
  logic [accs_pkg::CNT_W-1:0] bit_cnt;
  logic [accs_pkg::CNT_W-1:0] next_bit_cnt;
  logic [DIV_W-1:0]      div_cnt;
  logic [DIV_W-1:0]      next_div_cnt;
  logic                  started;
  logic                  next_started;
  logic [31:0]           shift_out;
  logic [31:0]           next_shift_out;
  logic [7:0]            shift_in;
  logic [7:0]            next_shift_in;
  logic [4:0]            addr;
  logic [4:0]            next_addr;
  logic                  int_mode;
  logic                  next_int_mode;
  logic                  sck_int;
  logic                  next_sck_int;
  logic                  next_sdo;
  logic                  next_sdo_oe;
  logic                  next_sck_oe;
  logic                  next_conv_start;
  logic                  next_cal_off;
  logic                  next_cal_fs;
  logic                  next_sleep;
  logic                  next_ext_mode;

  logic       cs_hi;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] in_word;
  logic [accs_pkg::DATA_BITS-1:0] res_data;
  logic       res_sign;

  always_comb begin
    cs_hi   = filt[accs_pkg::PIN_CS];
    cs_fall = filt_q[accs_pkg::PIN_CS] & ~filt[accs_pkg::PIN_CS];
    cs_rise = ~filt_q[accs_pkg::PIN_CS] & filt[accs_pkg::PIN_CS];
    in_word = {shift_in[6:0], filt[accs_pkg::PIN_SDI]};

    next_state      = state;
    next_por_cnt    = por_cnt;
    next_conv_cnt   = conv_cnt;
    next_bit_cnt    = bit_cnt;
    next_div_cnt    = div_cnt;
    next_started    = started;
    next_shift_out  = shift_out;
    next_shift_in   = shift_in;
    next_addr       = addr;
    next_int_mode   = int_mode;
    next_sck_int    = sck_int;
    next_conv_start = 1'b0;

    // Clock edges from the pin or the internal divider
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    if (state == accs_pkg::ACCS_DOUT && !cs_hi) begin
      if (int_mode) begin
        if (div_cnt == DIV_W'(SCK_HALF - 1)) begin
          next_div_cnt = '0;
          next_sck_int = ~sck_int;
          sck_rise     = ~sck_int;
          sck_fall     = sck_int;
        end else begin
          next_div_cnt = div_cnt + 1'b1;
        end
      end else begin
        sck_rise = ~filt_q[accs_pkg::PIN_SCK] & filt[accs_pkg::PIN_SCK];
        sck_fall = filt_q[accs_pkg::PIN_SCK] & ~filt[accs_pkg::PIN_SCK];
      end
    end

    // Clock mode sampled on select fall
    if (cs_fall) begin
      next_int_mode = filt[accs_pkg::PIN_SCK];
    end

    // Result word with range codes
    res_data = result_i.data;
    res_sign = ~result_i.data[accs_pkg::DATA_BITS-1];
    if (result_i.over) begin
      res_data = accs_pkg::OVER_DATA;
      res_sign = 1'b1;
    end else if (result_i.under) begin
      res_data = accs_pkg::UNDER_DATA;
      res_sign = 1'b0;
    end

    unique case (state)
      accs_pkg::ACCS_POR: begin
        if (por_cnt == POR_W'(POR_CYCLES - 1)) begin
          next_state      = accs_pkg::ACCS_CONV;
          next_conv_cnt   = '0;
          next_conv_start = 1'b1;
          next_int_mode   = filt[accs_pkg::PIN_SCK];
        end else begin
          next_por_cnt = por_cnt + 1'b1;
        end
      end
      accs_pkg::ACCS_CONV: begin
        if (conv_cnt == CONV_W'(CONV_CYCLES - 1)) begin
          next_state     = accs_pkg::ACCS_SLEEP;
          next_shift_out = {accs_pkg::HDR_READY, res_sign, res_data,
                            addr};
        end else begin
          next_conv_cnt = conv_cnt + 1'b1;
        end
      end
      accs_pkg::ACCS_SLEEP: begin
        if (!cs_hi) begin
          next_state   = accs_pkg::ACCS_DOUT;
          next_started = 1'b0;
          next_bit_cnt = '0;
          next_div_cnt = '0;
          next_sck_int = 1'b0;
        end
      end
      accs_pkg::ACCS_DOUT: begin
        if (cs_hi || cs_rise) begin
          if (started) begin
            next_state      = accs_pkg::ACCS_CONV;
            next_conv_cnt   = '0;
            next_conv_start = 1'b1;
          end else begin
            next_state = accs_pkg::ACCS_SLEEP;
          end
        end else if (sck_rise) begin
          next_started  = 1'b1;
          next_shift_in = in_word;
          next_bit_cnt  = bit_cnt + 1'b1;
          if (bit_cnt == accs_pkg::CNT_W'(accs_pkg::IN_BITS - 1) &&
              in_word[7:5] == accs_pkg::CTRL_LOAD) begin
            next_addr = in_word[4:0];
          end
          if (bit_cnt == accs_pkg::CNT_W'(accs_pkg::WORD_BITS - 1)) begin
            next_state      = accs_pkg::ACCS_CONV;
            next_conv_cnt   = '0;
            next_conv_start = 1'b1;
          end
        end else if (sck_fall && started) begin
          next_shift_out = {shift_out[30:0], 1'b0};
        end
      end
      default: begin
        next_state = accs_pkg::ACCS_POR;
      end
    endcase

    // Supply low holds the sequencer state, counters, shifters and address at power-on values
    if (!filt[accs_pkg::PIN_SUP]) begin
      next_state     = accs_pkg::ACCS_POR;
      next_por_cnt   = '0;
      next_conv_cnt  = '0;
      next_bit_cnt   = '0;
      next_div_cnt   = '0;
      next_started   = 1'b0;
      next_shift_out = '0;
      next_shift_in  = '0;
      next_addr      = accs_pkg::ADDR_RESET;
      next_int_mode  = 1'b0;
      next_sck_int   = 1'b0;
    end

    // Calibration phases inside the conversion
    next_cal_off = next_state == accs_pkg::ACCS_CONV &&
                   next_conv_cnt < CONV_W'(CAL_CYCLES);
    next_cal_fs  = next_state == accs_pkg::ACCS_CONV &&
                   next_conv_cnt >= CONV_W'(CAL_CYCLES) &&
                   next_conv_cnt < CONV_W'(2 * CAL_CYCLES);

    // Serial output: data in transfer, busy status otherwise
    if (next_state == accs_pkg::ACCS_DOUT) begin
      next_sdo = next_shift_out[31];
    end else begin
      next_sdo = next_state != accs_pkg::ACCS_SLEEP;
    end
    next_sdo_oe = ~cs_hi;
    next_sck_oe = next_state == accs_pkg::ACCS_DOUT && next_int_mode &&
                  !cs_hi;
    next_sleep    = next_state == accs_pkg::ACCS_SLEEP;
    next_ext_mode = ~next_int_mode;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state           <= accs_pkg::ACCS_POR;
      por_cnt         <= '0;
      conv_cnt        <= '0;
      bit_cnt         <= '0;
      div_cnt         <= '0;
      started         <= 1'b0;
      shift_out       <= '0;
      shift_in        <= '0;
      addr            <= accs_pkg::ADDR_RESET;
      int_mode        <= 1'b0;
      sck_int         <= 1'b0;
      sdo_o           <= 1'b0;
      sdo_oe_o        <= 1'b0;
      sck_oe_o        <= 1'b0;
      conv_start_o    <= 1'b0;
      cal_offset_o    <= 1'b0;
      cal_fullscale_o <= 1'b0;
      sleep_o         <= 1'b0;
      ext_sck_mode_o  <= 1'b1;
    end else if (en_i) begin
      state           <= next_state;
      por_cnt         <= next_por_cnt;
      conv_cnt        <= next_conv_cnt;
      bit_cnt         <= next_bit_cnt;
      div_cnt         <= next_div_cnt;
      started         <= next_started;
      shift_out       <= next_shift_out;
      shift_in        <= next_shift_in;
      addr            <= next_addr;
      int_mode        <= next_int_mode;
      sck_int         <= next_sck_int;
      sdo_o           <= next_sdo;
      sdo_oe_o        <= next_sdo_oe;
      sck_oe_o        <= next_sck_oe;
      conv_start_o    <= next_conv_start;
      cal_offset_o    <= next_cal_off;
      cal_fullscale_o <= next_cal_fs;
      sleep_o         <= next_sleep;
      ext_sck_mode_o  <= next_ext_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flop-driven status outputs
  assign sck_o          = sck_int;
  assign mux_address_o  = addr;

endmodule

// ===== accs_chk.sv
// Port assertions for the conversion cycle sequencer
module accs_chk (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // Pins
  input wire logic       supply_ok_i,
  input wire logic       cs_n_i,
  input wire logic       sdo_o,
  input wire logic       sdo_oe_o,
  // Datapath
  input wire logic [4:0] mux_address_o,
  input wire logic       conv_start_o,
  input wire logic       cal_offset_o,
  input wire logic       cal_fullscale_o,
  input wire logic       sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ///////////////////////////////////////////////////////////////////////////
  start_pulse_a: assert property (
    conv_start_o |=> !conv_start_o) else $error("start pulse too long");
  conv_run_a: assert property (
    conv_start_o |=> !sleep_o [*8]) else $error("conversion cut short");
  cal_first_a: assert property (
    conv_start_o |-> ##[0:1] cal_offset_o) else $error("no offset cal");
  cal_next_a: assert property (
    $fell(cal_offset_o) |-> cal_fullscale_o) else $error("no gain cal");
  hold_sleep_a: assert property (
    (cs_n_i && supply_ok_i) [*6] ##0 sleep_o |=> sleep_o)
    else $error("left sleep with select high");
  sdo_off_a: assert property (
    cs_n_i [*6] |-> !sdo_oe_o) else $error("output driven unselected");
  sdo_on_a: assert property (
    !cs_n_i [*6] |-> sdo_oe_o) else $error("output off while selected");
  busy_flag_a: assert property (
    (cal_offset_o || cal_fullscale_o) && sdo_oe_o
    && $past(cal_offset_o || cal_fullscale_o) |-> sdo_o)
    else $error("busy status missing");
  addr_keep_a: assert property (
    $changed(mux_address_o) |-> sdo_oe_o || mux_address_o == 5'h00)
    else $error("address changed outside transfer");
endmodule

bind accs_sequencer accs_chk chk_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok_i),
  .cs_n_i(cs_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .mux_address_o(mux_address_o), .conv_start_o(conv_start_o),
  .cal_offset_o(cal_offset_o), .cal_fullscale_o(cal_fullscale_o),
  .sleep_o(sleep_o));

// ===== accs_host_model.sv
// Host serial controller model for select, clock and data in
module accs_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      cs_n_o,
  output logic      sck_o,
  input  wire logic sck_i,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'h1;
    sck_o = 1'h0;
    sdi_o = 1'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Frame of n clock rises, select raised afterwards
  task automatic frame(input int n, input logic [7:0] din,
                       output logic [31:0] dout);
    dout = 32'h0;
    step(1);
    cs_n_o <= 1'h0;
    sdi_o <= din[7];
    step(8);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      dout = {dout[30:0], sdo_i};
      step(1);
      sck_o <= 1'h1;
      step(6);
      sck_o <= 1'h0;
      sdi_o <= (i < 7) ? din[6-i] : ~sdi_o;
      step(6);
    end
    if (n == 0) begin
      @(negedge clk_i);
      dout = {31'h0, sdo_i};
      step(1);
    end
    cs_n_o <= 1'h1;
    sdi_o <= ~sdi_o;
    step(6);
  endtask
  // Device-clocked frame: clock pin held high at select fall
  task automatic iframe(output logic [31:0] dout);
    logic prev_sck;
    logic prev_sdo;
    int   k;
    int   lim;
    dout = 32'h0;
    k = 0;
    lim = 0;
    step(1);
    sck_o <= 1'h1;
    step(6);
    cs_n_o <= 1'h0;
    sdi_o <= 1'h0;
    step(8);
    @(negedge clk_i);
    prev_sck = sck_i;
    prev_sdo = sdo_i;
    while (k < 32 && lim < 1200) begin
      @(negedge clk_i);
      if (sck_i && !prev_sck) begin
        dout = {dout[30:0], prev_sdo};
        k++;
      end
      prev_sck = sck_i;
      prev_sdo = sdo_i;
      lim++;
    end
    step(1);
    cs_n_o <= 1'h1;
    sck_o <= 1'h0;
    step(6);
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the conversion cycle sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 64;
  logic                   clk_i;
  logic                   rstn_i;
  logic                   supply_ok_i;
  logic                   cs_n;
  logic                   host_sck;
  logic                   sdi;
  logic                   sck_o;
  logic                   sck_oe_o;
  logic                   sdo_o;
  logic                   sleep_o;
  logic                   conv_start_o;
  logic                   ext_sck_mode_o;
  logic [4:0]             mux_address_o;
  logic [4:0]             sel;
  logic [4:0]             conv_addr;
  accs_pkg::accs_result_s result;
  accs_pkg::accs_result_s cur;
  int                     fails;
  int                     check_count;
  logic                   sck_pin;
  assign sck_pin = sck_oe_o ? sck_o : host_sck;
  accs_sequencer #(.POR_CYCLES(20), .CONV_CYCLES(CONV), .CAL_CYCLES(8),
    .SCK_HALF(16)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(1'h1), .supply_ok_i(supply_ok_i),
    .cs_n_i(cs_n), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(),
    .result_i(result), .mux_address_o(mux_address_o),
    .conv_start_o(conv_start_o), .cal_offset_o(), .cal_fullscale_o(),
    .sleep_o(sleep_o), .ext_sck_mode_o(ext_sck_mode_o));
  accs_host_model host_u (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(host_sck),
    .sck_i(sck_pin), .sdi_o(sdi), .sdo_i(sdo_o));
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  ///////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic await_sig(input int which, input int lim, output int n);
    n = 0;
    while ((which ? conv_start_o : sleep_o) !== 1'h1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  function automatic logic [31:0] exp_word(accs_pkg::accs_result_s r,
                                           logic [4:0] a);
    logic [23:0] d;
    d = r.over ? accs_pkg::OVER_DATA : r.under ? accs_pkg::UNDER_DATA : r.data;
    return {accs_pkg::HDR_READY, r.over | ~(r.under | d[23]), d, a};
  endfunction
  task automatic wrap_up();
    $display("CHECKS %0d MISMATCHES %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ///////////////////////////////////////////////////////////////////////////
  task automatic t_power(input string name);
    int n;
    @(negedge clk_i);
    check({name, " addr"}, 5'h00, mux_address_o);
    await_sig(1, 60, n);
    check({name, " por"}, 1'h1, n >= 16 && n < 60);
    check({name, " mode"}, 1'h1, ext_sck_mode_o);
    await_sig(0, 200, n);
    check({name, " conv"}, 1'h1, n >= CONV - 2 && n <= CONV + 8);
    $display("TEST %s done", name);
  endtask
  task automatic t_read(input string name, input logic [7:0] din,
                        input accs_pkg::accs_result_s nxt);
    logic [31:0] got;
    logic [31:0] e;
    int n;
    await_sig(0, 200, n);
    check({name, " sleep"}, 1'h1, sleep_o);
    @(posedge clk_i);
    result <= nxt;
    e = exp_word(cur, conv_addr);
    host_u.frame(32, din, got);
    @(negedge clk_i);
    check({name, " word"}, e, got);
    if (din[7:5] == accs_pkg::CTRL_LOAD) sel = din[4:0];
    check({name, " addr"}, sel, mux_address_o);
    check({name, " restart"}, 1'h0, sleep_o);
    cur = nxt;
    conv_addr = sel;
    $display("TEST %s done", name);
  endtask
  task automatic t_peek();
    logic [31:0] got;
    int n;
    await_sig(0, 200, n);
    host_u.frame(0, 8'h00, got);
    check("peek bit", 32'h0, got);
    repeat (4) @(negedge clk_i);
    check("peek sleep", 1'h1, sleep_o);
    $display("TEST peek done");
  endtask
  task automatic t_internal();
    logic [31:0] got;
    logic [31:0] e;
    int n;
    await_sig(0, 200, n);
    @(posedge clk_i);
    result <= 26'h0FEDCBA;
    e = exp_word(cur, conv_addr);
    host_u.iframe(got);
    @(negedge clk_i);
    check("int word", e, got);
    check("int mode", 1'h0, ext_sck_mode_o);
    check("int clock off", 1'h0, sck_oe_o);
    check("int restart", 1'h0, sleep_o);
    cur = 26'h0FEDCBA;
    conv_addr = sel;
    $display("TEST internal done");
  endtask
  task automatic t_abort();
    logic [31:0] got;
    logic [31:0] e;
    int n;
    await_sig(0, 200, n);
    @(posedge clk_i);
    result <= 26'h1000000;
    e = exp_word(cur, conv_addr);
    host_u.frame(4, 8'hA0, got);
    repeat (10) @(negedge clk_i);
    check("abort head", e >> 28, got);
    check("abort conv", 1'h0, sleep_o);
    host_u.frame(0, 8'h00, got);
    check("busy status", 1'h1, got);
    cur = 26'h1000000;
    conv_addr = sel;
    $display("TEST abort done");
  endtask
  task automatic t_supply();
    int n;
    await_sig(0, 200, n);
    @(posedge clk_i);
    supply_ok_i <= 1'h0;
    repeat (8) @(negedge clk_i);
    check("held addr", 5'h00, mux_address_o);
    check("held sleep", 1'h0, sleep_o);
    @(posedge clk_i);
    supply_ok_i <= 1'h1;
    sel = 5'h00;
    conv_addr = 5'h00;
    t_power("supply");
  endtask
  ///////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    fails++;
    $display("TIMEOUT");
    wrap_up();
  end
  initial begin
    rstn_i = 1'h0;
    supply_ok_i = 1'h1;
    result = 26'h0123456;
    cur = 26'h0123456;
    sel = 5'h00;
    conv_addr = 5'h00;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'h1;
    t_power("power");
    t_read("load", 8'hB3, 26'h0A5C3E1);
    t_peek();
    t_read("keep", 8'h9F, 26'h2000000);
    t_internal();
    t_abort();
    t_read("under", 8'h07, 26'h0123456);
    t_supply();
    t_read("fresh", 8'h00, 26'h0123456);
    wrap_up();
  end
endmodule
